// ===== design/amcr_regs.sv
// Purpose: trimming and test mode control registers behind an Avalon-MM slave
// Assumes: 250 MHz clk, async active-low rstn, 32-bit bus, byte lane 0 only
// Notes: every access answers with one waitrequest cycle
`timescale 1ns/1ns
module amcr_regs
  import amcr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [AMCR_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  output amcr_ctrl_type ctrl
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0] trim_mode_select_a;
    logic [7:0] trim_mode_select_b;
    logic waitrequest;
    logic [31:0] readdata;
    logic [1:0] response;
    amcr_ctrl_type ctrl;
  } amcr_state_type;

  amcr_state_type st;
  amcr_state_type next_st;
  amcr_ctrl_type dec_ctrl;
  logic [7:0] next_a_raw;
  logic [7:0] next_b_raw;

  function automatic logic [7:0] amcr_merge(input logic [7:0] old_val,
                                            input logic [7:0] wdata,
                                            input logic [7:0] wmask,
                                            input logic lane);
    amcr_merge = lane ? (wdata & wmask) : old_val;
  endfunction

  // ==========================================================================
  // bus and register update
  always_comb begin
    next_st = st;
    next_a_raw = st.trim_mode_select_a;
    next_b_raw = st.trim_mode_select_b;
    next_st.waitrequest = 1'b1;
    if ((avs_read || avs_write) && st.waitrequest) begin
      next_st.waitrequest = 1'b0;
      next_st.response = 2'h0;
      next_st.readdata = AMCR_UNMAPPED_READ;
      case (avs_address)
        AMCR_IDX_SELECT_A: begin
          next_st.readdata = {24'h000000, st.trim_mode_select_a};
          if (avs_write) begin
            next_a_raw = amcr_merge(st.trim_mode_select_a, avs_writedata[7:0],
                                    AMCR_WMASK_A, avs_byteenable[0]);
          end
        end
        AMCR_IDX_SELECT_B: begin
          next_st.readdata = {24'h000000, st.trim_mode_select_b};
          if (avs_write) begin
            next_b_raw = amcr_merge(st.trim_mode_select_b, avs_writedata[7:0],
                                    AMCR_WMASK_B, avs_byteenable[0]);
          end
        end
        default: begin
          next_st.response = 2'h3;
        end
      endcase
    end
    next_st.trim_mode_select_a = next_a_raw;
    next_st.trim_mode_select_b = next_b_raw;
    next_st.ctrl = dec_ctrl;
  end

  amcr_decode u_decode (
    .reg_a(next_a_raw),
    .reg_b(next_b_raw),
    .ctrl(dec_ctrl)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.trim_mode_select_a <= AMCR_RESET_A;
      st.trim_mode_select_b <= AMCR_RESET_B;
      st.waitrequest <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign avs_response = st.response;
  assign ctrl = st.ctrl;

  // ==========================================================================
  // reset and bus checks
  a_reset_clear: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |->
    st.trim_mode_select_a == AMCR_RESET_A && st.trim_mode_select_b == AMCR_RESET_B &&
    ctrl == '0 && avs_waitrequest && avs_response == 2'h0)
    else $error("state not cleared by reset");
  a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("answer late");
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
    !avs_waitrequest |=>
    avs_waitrequest)
    else $error("answer held too long");
  a_mapped_ok: assert property (@(posedge clk) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest && avs_address <= AMCR_IDX_SELECT_B |=>
    avs_response == 2'h0)
    else $error("mapped access refused");
  a_unmapped_error: assert property (@(posedge clk) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest && avs_address > AMCR_IDX_SELECT_B |=>
    avs_response == 2'h3 && avs_readdata == AMCR_UNMAPPED_READ)
    else $error("unmapped access not refused");
  a_read_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  // ==========================================================================
  // register content checks
  a_reserved_a_zero: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[7] == 1'b0)
    else $error("reserved bit of reg a set");
  a_reserved_b_zero: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[7:6] == 2'h0)
    else $error("reserved bits of reg b set");
  a_read_data_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && avs_waitrequest && avs_address == AMCR_IDX_SELECT_A |=>
    avs_readdata == {24'h000000, st.trim_mode_select_a})
    else $error("read of reg a wrong");
  a_read_data_b: assert property (@(posedge clk) disable iff (!rstn)
    avs_read && avs_waitrequest && avs_address == AMCR_IDX_SELECT_B |=>
    avs_readdata == {24'h000000, st.trim_mode_select_b})
    else $error("read of reg b wrong");
  a_write_lands_a: assert property (@(posedge clk) disable iff (!rstn)
    avs_write && avs_waitrequest && avs_address == AMCR_IDX_SELECT_A && avs_byteenable[0] |=>
    st.trim_mode_select_a == ($past(avs_writedata[7:0]) & AMCR_WMASK_A))
    else $error("write to reg a lost");
  a_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    (avs_write && !avs_waitrequest && avs_address == AMCR_IDX_SELECT_B && avs_byteenable[0])
    |=> st.trim_mode_select_b == ($past(avs_writedata[7:0]) & AMCR_WMASK_B))
    else $error("write to reg b lost");
  a_lane_off_keeps: assert property (@(posedge clk) disable iff (!rstn)
    avs_write && avs_waitrequest && !avs_byteenable[0] |=>
    $stable(st.trim_mode_select_a) && $stable(st.trim_mode_select_b))
    else $error("write with lane off landed");
  a_unmapped_keeps: assert property (@(posedge clk) disable iff (!rstn)
    avs_write && avs_waitrequest && avs_address > AMCR_IDX_SELECT_B |=>
    $stable(st.trim_mode_select_a) && $stable(st.trim_mode_select_b))
    else $error("unmapped write landed");
  a_idle_keeps: assert property (@(posedge clk) disable iff (!rstn)
    !(avs_write && avs_waitrequest) |=>
    $stable(st.trim_mode_select_a) && $stable(st.trim_mode_select_b))
    else $error("register changed without write");

  // ==========================================================================
  // decode checks
  a_judge_normal: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[6:5] == 2'h0 |->
    ctrl.judge_control_field == judge_normal)
    else $error("normal judge missing");
  a_judge_force: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[6:5] == 2'h1 |->
    ctrl.judge_control_field == judge_force_positive)
    else $error("positive force missing");
  a_judge_negative: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[6:5] == 2'h2 |->
    ctrl.judge_control_field == judge_force_negative)
    else $error("negative force missing");
  a_judge_reserved: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[6:5] == 2'h3 |->
    ctrl.judge_control_field == judge_normal)
    else $error("reserved judge code not normal");
  a_adjust_route: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] <= 4'h9 |->
    ctrl.adjust_select_field == st.trim_mode_select_a[4:1])
    else $error("adjust route mismatch");
  a_adjust_normal: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h0 |->
    ctrl.adjust_select_field == adjust_normal)
    else $error("normal adjust missing");
  a_adjust_vref: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h1 |->
    ctrl.adjust_select_field == route_ref_voltage)
    else $error("reference voltage route missing");
  a_adjust_reference_current: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h2 |->
    ctrl.adjust_select_field == route_ref_current)
    else $error("reference current route missing");
  a_adjust_osc: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h3 |->
    ctrl.adjust_select_field == route_oscillator)
    else $error("oscillator route missing");
  a_adjust_temp: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h4 |->
    ctrl.adjust_select_field == route_temp_voltage)
    else $error("temperature route missing");
  a_adjust_pos_thr: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h5 |->
    ctrl.adjust_select_field == route_pos_threshold)
    else $error("positive threshold route missing");
  a_adjust_neg_thr: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h6 |->
    ctrl.adjust_select_field == route_neg_threshold)
    else $error("negative threshold route missing");
  a_adjust_pos_hys: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h7 |->
    ctrl.adjust_select_field == route_pos_hysteresis)
    else $error("positive hysteresis route missing");
  a_adjust_neg_hys: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h8 |->
    ctrl.adjust_select_field == route_neg_hysteresis)
    else $error("negative hysteresis route missing");
  a_adjust_judge_thr: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] == 4'h9 |->
    ctrl.adjust_select_field == route_judge_threshold)
    else $error("judge threshold route missing");
  a_adjust_reserved: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] >= 4'hA |->
    ctrl.adjust_select_field == adjust_normal)
    else $error("reserved adjust code routed");
  a_mem_power_bit: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[0] |->
    ctrl.memory_always_on)
    else $error("store not powered with bit set");
  a_mem_intermittent: assert property (@(posedge clk) disable iff (!rstn)
    !st.trim_mode_select_a[0] && (st.trim_mode_select_a[4:1] == 4'h0 ||
    st.trim_mode_select_a[4:1] >= 4'hA) |-> !ctrl.memory_always_on)
    else $error("store powered in normal mode");
  a_mem_temp_route: assert property (@(posedge clk) disable iff (!rstn)
    (st.trim_mode_select_a[4:1] == 4'h4 && !st.trim_mode_select_a[0]) |->
    !ctrl.memory_always_on)
    else $error("temp route self powered");
  a_mem_self_power: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_a[4:1] inside {[4'h1:4'h3], [4'h5:4'h9]} |->
    ctrl.memory_always_on)
    else $error("adjust route not self powered");
  a_input_sensor: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[5:4] == 2'h0 |->
    ctrl.input_select_field == input_sensor)
    else $error("sensor input missing");
  a_input_ref: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[5:4] == 2'h1 |->
    ctrl.input_select_field == input_internal_ref)
    else $error("reference input missing");
  a_input_small: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[5:4] == 2'h2 |->
    ctrl.input_select_field == input_internal_small)
    else $error("small voltage input missing");
  a_input_select: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[5:4] == 2'h3 |->
    ctrl.input_select_field == input_sensor)
    else $error("reserved input code used");
  a_offset_drift: assert property (@(posedge clk) disable iff (!rstn)
    ctrl.offset_drift_disable == st.trim_mode_select_b[3])
    else $error("offset drift mismatch");
  a_sens_drift: assert property (@(posedge clk) disable iff (!rstn)
    ctrl.sens_drift_disable == st.trim_mode_select_b[2])
    else $error("sens drift mismatch");
  a_char_normal: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[1:0] == 2'h0 |->
    ctrl.characteristic_select == characteristic_normal)
    else $error("normal characteristic missing");
  a_char_second: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[1:0] == 2'h1 |->
    ctrl.characteristic_select == second_order_only)
    else $error("second order select missing");
  a_char_select: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[1:0] == 2'h2 |->
    ctrl.characteristic_select == first_order_only)
    else $error("first order select missing");
  a_char_reserved: assert property (@(posedge clk) disable iff (!rstn)
    st.trim_mode_select_b[1:0] == 2'h3 |->
    ctrl.characteristic_select == characteristic_normal)
    else $error("reserved characteristic code used");

  // ==========================================================================
  // scenario covers
  c_write_a: cover property (@(posedge clk) disable iff (!rstn)
    avs_write && !avs_waitrequest && avs_address == AMCR_IDX_SELECT_A);
  c_read_b: cover property (@(posedge clk) disable iff (!rstn)
    avs_read && !avs_waitrequest && avs_address == AMCR_IDX_SELECT_B);
  c_temp_route: cover property (@(posedge clk) disable iff (!rstn)
    ctrl.adjust_select_field == route_temp_voltage);
  c_unmapped: cover property (@(posedge clk) disable iff (!rstn) avs_response == 2'h3);
  c_lane_off: cover property (@(posedge clk) disable iff (!rstn)
    avs_write && !avs_waitrequest && !avs_byteenable[0]);

endmodule

// ===== design/amcr_pkg.sv
// Purpose: shared constants and carriers for the adjustment mode control registers
// Assumes: Avalon-MM slave, 32-bit data, word-addressed by index times four
// Notes: offsets 00 and 01 are word indices
package amcr_pkg;

  // ==========================================================================
  // register map
  localparam logic [3:0] AMCR_IDX_SELECT_A = 4'h0;
  localparam logic [3:0] AMCR_IDX_SELECT_B = 4'h1;
  localparam logic [1:0] AMCR_ADDR_LSB = 2'h2;
  localparam int AMCR_ADDR_W = 4;
  localparam logic [7:0] AMCR_RESET_A = 8'h00;
  localparam logic [7:0] AMCR_RESET_B = 8'h00;
  localparam logic [7:0] AMCR_WMASK_A = 8'h7F;
  localparam logic [7:0] AMCR_WMASK_B = 8'h3F;
  localparam logic [31:0] AMCR_UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================================
  // field positions
  localparam int AMCR_JUDGE_LSB = 5;
  localparam int AMCR_ADJUST_LSB = 1;
  localparam int AMCR_MEMPWR_BIT = 0;
  localparam int AMCR_INPUT_LSB = 4;
  localparam int AMCR_OFFSET_BIT = 3;
  localparam int AMCR_SENS_BIT = 2;
  localparam int AMCR_CHAR_LSB = 0;

  // ==========================================================================
  // field encodings
  typedef enum logic [1:0] {
    judge_normal = 2'h0,
    judge_force_positive = 2'h1,
    judge_force_negative = 2'h2
  } amcr_judge_type;

  typedef enum logic [3:0] {
    adjust_normal = 4'h0,
    route_ref_voltage = 4'h1,
    route_ref_current = 4'h2,
    route_oscillator = 4'h3,
    route_temp_voltage = 4'h4,
    route_pos_threshold = 4'h5,
    route_neg_threshold = 4'h6,
    route_pos_hysteresis = 4'h7,
    route_neg_hysteresis = 4'h8,
    route_judge_threshold = 4'h9
  } amcr_adjust_type;

  typedef enum logic [1:0] {
    input_sensor = 2'h0,
    input_internal_ref = 2'h1,
    input_internal_small = 2'h2
  } amcr_input_type;

  typedef enum logic [1:0] {
    characteristic_normal = 2'h0,
    second_order_only = 2'h1,
    first_order_only = 2'h2
  } amcr_char_type;

  // ==========================================================================
  // decoded analog controls
  typedef struct packed {
    amcr_judge_type judge_control_field;
    amcr_adjust_type adjust_select_field;
    logic memory_always_on;
    amcr_input_type input_select_field;
    logic offset_drift_disable;
    logic sens_drift_disable;
    amcr_char_type characteristic_select;
  } amcr_ctrl_type;

endpackage

// ===== design/amcr_decode.sv
// Purpose: decodes the two raw trim registers into analog control selects
// Assumes: inputs are the next-state register values; the caller registers the output
// Notes: purely combinational, reserved codes collapse to normal
`timescale 1ns/1ns
module amcr_decode
  import amcr_pkg::*;
(
  input wire logic [7:0] reg_a,
  input wire logic [7:0] reg_b,
  output amcr_ctrl_type ctrl
);

  always_comb begin
    ctrl = '0;
    // ========================================================================
    // first register
    case (reg_a[AMCR_JUDGE_LSB +: 2])
      2'h1: ctrl.judge_control_field = judge_force_positive;
      2'h2: ctrl.judge_control_field = judge_force_negative;
      default: ctrl.judge_control_field = judge_normal;
    endcase
    if (reg_a[AMCR_ADJUST_LSB +: 4] <= 4'h9) begin
      ctrl.adjust_select_field = amcr_adjust_type'(reg_a[AMCR_ADJUST_LSB +: 4]);
    end else begin
      ctrl.adjust_select_field = adjust_normal;
    end
    // store powered when bit set; temp route and normal need the bit, other routes self-power
    ctrl.memory_always_on = reg_a[AMCR_MEMPWR_BIT] ||
      (ctrl.adjust_select_field != adjust_normal &&
       ctrl.adjust_select_field != route_temp_voltage);
    // ========================================================================
    // second register
    case (reg_b[AMCR_INPUT_LSB +: 2])
      2'h1: ctrl.input_select_field = input_internal_ref;
      2'h2: ctrl.input_select_field = input_internal_small;
      default: ctrl.input_select_field = input_sensor;
    endcase
    ctrl.offset_drift_disable = reg_b[AMCR_OFFSET_BIT];
    ctrl.sens_drift_disable = reg_b[AMCR_SENS_BIT];
    case (reg_b[AMCR_CHAR_LSB +: 2])
      2'h1: ctrl.characteristic_select = second_order_only;
      2'h2: ctrl.characteristic_select = first_order_only;
      default: ctrl.characteristic_select = characteristic_normal;
    endcase
  end

endmodule

// ===== testbench/amcr_regs_tb.sv
// Purpose: self-checking bench for the trim mode control registers
// Assumes: Avalon-MM master held until waitrequest is sampled low
// Notes: expected answers are queued by the driver and popped by the monitor
`timescale 1ns/1ns
module amcr_regs_tb
  import amcr_pkg::*;
;
  typedef struct packed {
    logic is_rd;
    logic [31:0] rdata;
    logic [1:0] resp;
    amcr_ctrl_type ctrl;
  } amcr_note_type;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [AMCR_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  amcr_ctrl_type ctrl;
  logic [7:0] sa = 8'h00;
  logic [7:0] sb = 8'h00;
  amcr_note_type q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  amcr_regs uut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .ctrl(ctrl));

  always #2 clk = ~clk;

  // ==========================================================================
  // expectation model
  function automatic amcr_ctrl_type dec(input logic [7:0] a, input logic [7:0] b);
    amcr_ctrl_type c;
    c.judge_control_field = (a[6:5] == 2'h3) ? judge_normal : amcr_judge_type'(a[6:5]);
    c.adjust_select_field = (a[4:1] > 4'h9) ? adjust_normal : amcr_adjust_type'(a[4:1]);
    c.memory_always_on = a[0] | (a[4:1] != 4'h0 && a[4:1] != 4'h4 && a[4:1] <= 4'h9);
    c.input_select_field = (b[5:4] == 2'h3) ? input_sensor : amcr_input_type'(b[5:4]);
    c.offset_drift_disable = b[3];
    c.sens_drift_disable = b[2];
    c.characteristic_select = (b[1:0] == 2'h3) ? characteristic_normal
      : amcr_char_type'(b[1:0]);
    return c;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================================
  // bus master
  task automatic bus(input logic rd, input logic [3:0] idx, input logic [31:0] wd,
                     input logic [3:0] be);
    amcr_note_type n;
    @(posedge clk);
    if (!rd && idx == 4'h0 && be[0]) sa = wd[7:0] & 8'h7F;
    if (!rd && idx == 4'h1 && be[0]) sb = wd[7:0] & 8'h3F;
    n.is_rd = rd;
    n.resp = (idx > 4'h1) ? 2'h3 : 2'h0;
    n.rdata = (idx == 4'h0) ? {24'h0, sa} : (idx == 4'h1) ? {24'h0, sb} : 32'h0;
    n.ctrl = dec(sa, sb);
    q.push_back(n);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= idx;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ==========================================================================
  // monitor
  always @(posedge clk) begin
    amcr_note_type n;
    if (rstn === 1'b1 && avs_waitrequest === 1'b0) begin
      if (q.size() == 0) begin
        check("note queue", 32'h1, 32'h0);
      end else begin
        n = q.pop_front();
        if (n.is_rd) check("readdata", avs_readdata, n.rdata);
        check("response", {30'h0, avs_response}, {30'h0, n.resp});
        check("ctrl", {19'h0, ctrl}, {19'h0, n.ctrl});
      end
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h523e));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    check("ctrl at reset", {19'h0, ctrl}, 32'h0);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    bus(1'b1, 4'h1, 32'h0, 4'hF);
    for (int i = 0; i < 32; i++) begin
      bus(1'b0, 4'h0, 32'({$urandom, i[1:0], i[3:0], i[4]}), {3'($urandom), 1'b1});
      bus(1'b1, 4'h0, $urandom, 4'hF);
    end
    for (int i = 0; i < 64; i++) begin
      bus(1'b0, 4'h1, 32'({$urandom, i[5:0]}), {3'($urandom), 1'b1});
      bus(1'b1, 4'h1, $urandom, 4'hF);
    end
    // lane 0 off, unmapped places, then random traffic
    bus(1'b0, 4'h0, 32'hFF, 4'hE);
    bus(1'b0, 4'h1, 32'hFF, 4'h0);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    for (int i = 2; i < 16; i++) begin
      bus(1'b0, 4'(i), $urandom, 4'hF);
      bus(1'b1, 4'(i), 32'h0, 4'hF);
    end
    for (int i = 0; i < 60; i++) begin
      bus(1'($urandom), 4'($urandom % 3), $urandom, 4'($urandom));
    end
    bus(1'b0, 4'h0, 32'h09, 4'h1);
    bus(1'b0, 4'h1, 32'h3F, 4'h1);
    // second reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    sa = 8'h00;
    sb = 8'h00;
    check("ctrl after reset", {19'h0, ctrl}, 32'h0);
    bus(1'b1, 4'h0, 32'h0, 4'hF);
    bus(1'b1, 4'h1, 32'h0, 4'hF);
    repeat (3) @(posedge clk);
    check("queue empty", 32'(q.size()), 32'h0);
    print_verdict();
  end
endmodule
